/* byte_fifo.v */
// small fifo with registered read data, used between the disk byte stream and buffer memory
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH  = 8,
  parameter DEPTH  = 8,
  parameter ADDR_W = 3
) (
  input  wire             i_ref_clk,
  input  wire             i_rst,
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  output reg              o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);
  // depth must be a power of two so the pointers wrap on their own
  localparam [ADDR_W:0] FULL = DEPTH[ADDR_W:0];

  reg [WIDTH-1:0]  mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_q;
  reg [ADDR_W-1:0] rd_ptr_q;
  reg [ADDR_W:0]   count_q;

  wire push = i_in_valid & o_in_ready;
  wire pop  = (count_q != {(ADDR_W+1){1'b0}}) & (~o_out_valid | i_out_ready);

  assign o_in_ready = (count_q != FULL);

  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q    <= {ADDR_W{1'b0}};
      rd_ptr_q    <= {ADDR_W{1'b0}};
      count_q     <= {(ADDR_W+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q    <= rd_ptr_q + 1'b1;
        o_out_data  <= mem[rd_ptr_q];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

/* disk_cmd_map.vh */
// register address, command word fields, opcodes and field lengths of the disk command issue block
`ifndef DISK_CMD_MAP_VH
`define DISK_CMD_MAP_VH

`define DISK_COMMAND_WORD_ADDR  8'h10
`define DISK_COMMAND_WORD_RESET 8'h00

`define CMD_MULTI_BIT     7
`define CMD_START_SEL_BIT 6
`define CMD_OP_MSB        4

`define OP_NO_OPERATION   5'h00
`define OP_IGNORE_HDR_LO  5'h04
`define OP_COMPARE_HDR_LO 5'h08
`define OP_COMPARE_HDR_HI 5'h0b
`define OP_STORE_HEADERS  5'h08

`define DATA_IGNORE 2'h0
`define DATA_VERIFY 2'h1
`define DATA_WRITE  2'h2
`define DATA_READ   2'h3

`define DRIVE_SOFT   2'h0
`define DRIVE_PSEUDO 2'h1
`define DRIVE_HARD   2'h2

`define CHECK_CRC16 2'h0
`define CHECK_ECC32 2'h1
`define CHECK_ECC48 2'h2
`define CHECK_ECC56 2'h3
`define CHECK_BYTES_CRC16 17'h00002
`define CHECK_BYTES_ECC32 17'h00004
`define CHECK_BYTES_ECC48 17'h00006
`define CHECK_BYTES_ECC56 17'h00007

`define MIN_DATA_WORDS   16'h0008
`define INDEX_MISS_LIMIT 2'h2
`define PAD_BYTE         8'h00

`define FIFO_WIDTH  8
`define FIFO_DEPTH  8
`define FIFO_ADDR_W 3

`endif

/* disk_command_issue.v */
// disk command issue: command word, start condition, per-sector header and data segment sequencing
//
// What this block does
// - writing the command word launches an operation once its start condition holds
// - bit 7 picks multi-sector, bit 6 picks the start condition
// - single sector ends after one; multi steps number and count until zero
// - start-on-timer-zero starts at timer zero and ignores the start select
// - select one: soft immediate, pseudo after mark found, hard index or sector
// - select zero: soft index, pseudo first mark after index, hard index
// - command word copied to a working copy at start; next may be written
// - no operation counts gap, check and postamble, no gates, then completes
// - multi-sector no operation still steps sector number and count
// - opcodes 4-7 find header sync, count header, optionally check header
// - opcode 4 finds data sync, counts data, checks only when enabled
// - verify compares each data byte with buffer byte, optional data check
// - 6/7 write or read data; A/B do so only after header match
// - opcode 8 stores header bytes, pads odd counts, and syncs and checks as a header compare
// - single compare ends on match, error, or two index pulses unmatched
// - compare header verify data turns buffer parity checking off
// - data field length 16 bytes up to 131070 bytes in two-byte steps
// - each segment carries 16-bit check code or 32/48/56-bit correcting code
// - visible counts never change while the read strobe is active
// - gap field before each preamble spaces read gate against write gate
`timescale 1ns/10ps
`include "disk_cmd_map.vh"
module disk_command_issue (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_wr_strobe,
  input  wire        i_rd_strobe,
  input  wire        i_start_on_timer_zero,
  input  wire        i_timer_zero,
  input  wire [1:0]  i_drive_type,
  input  wire        i_index,
  input  wire        i_sector_pulse,
  input  wire        i_address_mark_found,
  input  wire        i_byte_tick,
  input  wire [7:0]  i_rd_byte,
  input  wire        i_header_sync_found,
  input  wire        i_data_sync_found,
  input  wire        i_header_match,
  input  wire        i_header_check_en,
  input  wire        i_data_check_en,
  input  wire        i_check_error,
  input  wire [1:0]  i_check_type,
  input  wire [7:0]  i_gap_bytes,
  input  wire [7:0]  i_post_index_gap_bytes,
  input  wire [3:0]  i_header_bytes,
  input  wire [15:0] i_data_words,
  input  wire [7:0]  i_postamble_bytes,
  input  wire [7:0]  i_sector_number_init,
  input  wire [7:0]  i_sector_count_init,
  input  wire [7:0]  i_buf_rd_data,
  input  wire        i_buf_rd_valid,
  output wire        o_buf_rd_ready,
  output wire        o_buf_wr_valid,
  output wire [7:0]  o_buf_wr_data,
  input  wire        i_buf_wr_ready,
  output wire        o_read_gate,
  output wire        o_write_gate,
  output reg  [7:0]  o_wr_byte,
  output wire        o_busy,
  output reg         o_op_complete,
  output reg         o_op_error,
  output wire        o_buf_parity_check_en,
  output reg  [7:0]  o_sector_number,
  output reg  [7:0]  o_sector_count
);
  localparam [12:0] S_IDLE      = 13'h0001;
  localparam [12:0] S_WAIT      = 13'h0002;
  localparam [12:0] S_POST_GAP  = 13'h0004;
  localparam [12:0] S_HDR_GAP   = 13'h0008;
  localparam [12:0] S_HDR_SYNC  = 13'h0010;
  localparam [12:0] S_HDR_BYTES = 13'h0020;
  localparam [12:0] S_HDR_CHECK = 13'h0040;
  localparam [12:0] S_DATA_GAP  = 13'h0080;
  localparam [12:0] S_DATA_SYNC = 13'h0100;
  localparam [12:0] S_DATA_BYTE = 13'h0200;
  localparam [12:0] S_DATA_CHK  = 13'h0400;
  localparam [12:0] S_POSTAMBLE = 13'h0800;
  localparam [12:0] S_DONE      = 13'h1000;

  function [16:0] check_len;
    input [1:0] kind;
    begin
      case (kind)
        `CHECK_CRC16: check_len = `CHECK_BYTES_CRC16;
        `CHECK_ECC32: check_len = `CHECK_BYTES_ECC32;
        `CHECK_ECC48: check_len = `CHECK_BYTES_ECC48;
        default:      check_len = `CHECK_BYTES_ECC56;
      endcase
    end
  endfunction

  function is_compare;
    input [4:0] code;
    begin
      is_compare = (code >= `OP_COMPARE_HDR_LO) && (code <= `OP_COMPARE_HDR_HI);
    end
  endfunction

  function is_supported;
    input [4:0] code;
    begin
      is_supported = (code == `OP_NO_OPERATION) ||
                     ((code >= `OP_IGNORE_HDR_LO) && (code <= `OP_COMPARE_HDR_HI));
    end
  endfunction

  reg [7:0]  cmd_q;
  reg        pending_q;
  reg [7:0]  work_q;
  reg [12:0] state_q;
  reg [16:0] cnt_q;
  reg [7:0]  sec_num_q;
  reg [7:0]  sec_cnt_q;
  reg        seen_index_q;
  reg [1:0]  miss_q;
  reg        pad_q;
  reg        start_met;

  wire [4:0] op        = work_q[`CMD_OP_MSB:0];
  wire       multi     = work_q[`CMD_MULTI_BIT];
  wire       start_sel = work_q[`CMD_START_SEL_BIT];
  wire [1:0] data_kind = op[1:0];
  wire       is_nop    = (op == `OP_NO_OPERATION);
  wire       compare   = is_compare(op);
  wire       writing   = ~is_nop & (data_kind == `DATA_WRITE);
  wire       verifying = ~is_nop & (data_kind == `DATA_VERIFY);
  wire       reading   = ~is_nop & (data_kind == `DATA_READ);

  wire       cmd_hit   = i_wr_strobe & (i_reg_addr == `DISK_COMMAND_WORD_ADDR);
  wire       load      = (state_q == S_IDLE) & pending_q;
  wire       cnt_end   = (cnt_q == 17'h00000) | ((cnt_q == 17'h00001) & i_byte_tick);

  // shorter programmed fields are raised to the 16 byte floor
  wire [15:0] words    = (i_data_words < `MIN_DATA_WORDS) ? `MIN_DATA_WORDS : i_data_words;
  wire [16:0] data_len = {words, 1'b0};
  wire [16:0] chk_len  = check_len(i_check_type);
  wire [16:0] gap_len  = {9'h000, i_gap_bytes};
  wire [16:0] post_len = {9'h000, i_postamble_bytes};
  wire [16:0] hdr_len  = {13'h0000, i_header_bytes};

  // disk to buffer path: stored headers, pad bytes and read data
  wire       store_hdr = (state_q == S_HDR_BYTES) & (op == `OP_STORE_HEADERS) & i_byte_tick;
  wire       store_dat = (state_q == S_DATA_BYTE) & reading & i_byte_tick;
  wire       push      = store_hdr | store_dat | pad_q;
  wire [7:0] push_data = pad_q ? `PAD_BYTE : i_rd_byte;
  wire       fifo_ready;
  // the disk cannot be stalled, so a full fifo ends the command with an error
  wire       overrun   = push & ~fifo_ready;

  // buffer to disk path: write data and verify reference bytes
  wire       need_buf  = (state_q == S_DATA_BYTE) & (writing | verifying) & i_byte_tick;
  wire       underrun  = need_buf & ~i_buf_rd_valid;
  wire       mismatch  = need_buf & verifying & i_buf_rd_valid & (i_buf_rd_data != i_rd_byte);
  wire       fault     = overrun | underrun | mismatch;
  wire [7:0] sec_cnt_dec = sec_cnt_q - 8'h01;

  assign o_buf_rd_ready = need_buf;
  assign o_busy         = (state_q != S_IDLE) | pending_q;
  // parity of buffer memory is not checked while compare header verify data runs
  assign o_buf_parity_check_en = (state_q != S_IDLE) & (writing | verifying) & ~(compare & verifying);

  // gates are decoded from state; the gap states hold both low so no splice reaches the synchroniser
  assign o_read_gate  = ~is_nop & (
                        (state_q == S_HDR_SYNC) | (state_q == S_HDR_BYTES) | (state_q == S_HDR_CHECK) |
                        (~writing & ((state_q == S_DATA_SYNC) | (state_q == S_DATA_BYTE) |
                                     (state_q == S_DATA_CHK))));
  assign o_write_gate = writing & ((state_q == S_DATA_BYTE) | (state_q == S_DATA_CHK));

  always @* begin
    start_met = 1'b0;
    if (i_start_on_timer_zero) begin
      start_met = i_timer_zero;
    end else if (start_sel) begin
      case (i_drive_type)
        `DRIVE_SOFT:   start_met = 1'b1;
        `DRIVE_PSEUDO: start_met = i_address_mark_found;
        `DRIVE_HARD:   start_met = i_index | i_sector_pulse;
        default:       start_met = 1'b0;
      endcase
    end else begin
      case (i_drive_type)
        `DRIVE_SOFT:   start_met = i_index;
        `DRIVE_PSEUDO: start_met = i_address_mark_found & seen_index_q;
        `DRIVE_HARD:   start_met = i_index;
        default:       start_met = 1'b0;
      endcase
    end
  end

  byte_fifo #(
    .WIDTH  (`FIFO_WIDTH),
    .DEPTH  (`FIFO_DEPTH),
    .ADDR_W (`FIFO_ADDR_W)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .i_in_data   (push_data),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_buf_wr_valid),
    .o_out_data  (o_buf_wr_data),
    .i_out_ready (i_buf_wr_ready)
  );

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q           <= `DISK_COMMAND_WORD_RESET;
      pending_q       <= 1'b0;
      work_q          <= `DISK_COMMAND_WORD_RESET;
      state_q         <= S_IDLE;
      cnt_q           <= 17'h00000;
      sec_num_q       <= 8'h00;
      sec_cnt_q       <= 8'h00;
      seen_index_q    <= 1'b0;
      miss_q          <= 2'h0;
      pad_q           <= 1'b0;
      o_wr_byte       <= 8'h00;
      o_op_complete   <= 1'b0;
      o_op_error      <= 1'b0;
      o_sector_number <= 8'h00;
      o_sector_count  <= 8'h00;
    end else begin
      o_op_complete <= 1'b0;
      pad_q         <= 1'b0;
      if (cmd_hit) begin
        cmd_q <= i_reg_wdata;
      end
      // a write landing in the load cycle keeps the new word pending
      pending_q <= cmd_hit | (pending_q & ~load);
      // visible copies freeze while the processor reads
      if (!i_rd_strobe) begin
        o_sector_number <= sec_num_q;
        o_sector_count  <= sec_cnt_q;
      end
      if (need_buf && i_buf_rd_valid && writing) begin
        o_wr_byte <= i_buf_rd_data;
      end
      if (cnt_q != 17'h00000 && i_byte_tick) begin
        cnt_q <= cnt_q - 17'h00001;
      end
      if (fault && state_q != S_IDLE) begin
        o_op_error <= 1'b1;
        state_q    <= S_DONE;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (load) begin
              work_q       <= cmd_q;
              sec_num_q    <= i_sector_number_init;
              sec_cnt_q    <= i_sector_count_init;
              seen_index_q <= 1'b0;
              miss_q       <= 2'h0;
              o_op_error   <= 1'b0;
              state_q      <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (!is_supported(op)) begin
              o_op_error <= 1'b1;
              state_q    <= S_DONE;
            end else if (start_met) begin
              cnt_q   <= {9'h000, i_post_index_gap_bytes};
              state_q <= S_POST_GAP;
            end else if (i_index) begin
              seen_index_q <= 1'b1;
            end
          end
          S_POST_GAP: begin
            if (cnt_end) begin
              cnt_q   <= is_nop ? chk_len : gap_len;
              state_q <= is_nop ? S_DATA_CHK : S_HDR_GAP;
            end
          end
          S_HDR_GAP: begin
            if (cnt_end) begin
              state_q <= S_HDR_SYNC;
            end
          end
          S_HDR_SYNC: begin
            if (i_header_sync_found) begin
              cnt_q   <= hdr_len;
              state_q <= S_HDR_BYTES;
            end
          end
          S_HDR_BYTES: begin
            if (cnt_end) begin
              pad_q   <= (op == `OP_STORE_HEADERS) & i_header_bytes[0];
              cnt_q   <= chk_len;
              state_q <= S_HDR_CHECK;
            end
          end
          S_HDR_CHECK: begin
            if (cnt_end) begin
              if (i_header_check_en && i_check_error) begin
                o_op_error <= 1'b1;
                state_q    <= S_DONE;
              end else if (!compare || i_header_match) begin
                cnt_q   <= gap_len;
                state_q <= S_DATA_GAP;
              end else begin
                cnt_q   <= gap_len;
                state_q <= S_HDR_GAP;
              end
            end
          end
          S_DATA_GAP: begin
            if (cnt_end) begin
              cnt_q   <= data_len;
              state_q <= writing ? S_DATA_BYTE : S_DATA_SYNC;
            end
          end
          S_DATA_SYNC: begin
            if (i_data_sync_found) begin
              cnt_q   <= data_len;
              state_q <= S_DATA_BYTE;
            end
          end
          S_DATA_BYTE: begin
            if (cnt_end) begin
              cnt_q   <= chk_len;
              state_q <= S_DATA_CHK;
            end
          end
          S_DATA_CHK: begin
            if (cnt_end) begin
              if (!is_nop && !writing && i_data_check_en && i_check_error) begin
                o_op_error <= 1'b1;
                state_q    <= S_DONE;
              end else begin
                cnt_q   <= post_len;
                state_q <= S_POSTAMBLE;
              end
            end
          end
          S_POSTAMBLE: begin
            if (cnt_end) begin
              if (multi) begin
                sec_num_q <= sec_num_q + 8'h01;
                sec_cnt_q <= sec_cnt_dec;
                if (sec_cnt_dec == 8'h00) begin
                  state_q <= S_DONE;
                end else if (is_nop) begin
                  cnt_q   <= {9'h000, i_post_index_gap_bytes};
                  state_q <= S_POST_GAP;
                end else begin
                  cnt_q   <= gap_len;
                  state_q <= S_HDR_GAP;
                end
              end else begin
                state_q <= S_DONE;
              end
            end
          end
          S_DONE: begin
            o_op_complete <= 1'b1;
            state_q       <= S_IDLE;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
        // a compare that passes a second index without a match gives up
        if (compare && i_index &&
            (state_q == S_HDR_GAP || state_q == S_HDR_SYNC ||
             state_q == S_HDR_BYTES || state_q == S_HDR_CHECK)) begin
          if (miss_q == `INDEX_MISS_LIMIT - 2'h1) begin
            o_op_error <= 1'b1;
            state_q    <= S_DONE;
          end
          miss_q <= miss_q + 2'h1;
        end
      end
    end
  end
endmodule

/* disk_command_monitor.sv */
// concurrent checks on the command issue block ports
`timescale 1ns/10ps
module disk_command_monitor (
  input wire       i_ref_clk,
  input wire       i_rst,
  input wire [7:0] i_reg_addr,
  input wire       i_wr_strobe,
  input wire       i_rd_strobe,
  input wire       i_buf_wr_ready,
  input wire       o_buf_wr_valid,
  input wire [7:0] o_buf_wr_data,
  input wire       o_read_gate,
  input wire       o_write_gate,
  input wire       o_busy,
  input wire       o_op_complete,
  input wire       o_op_error,
  input wire [7:0] o_sector_number,
  input wire [7:0] o_sector_count
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  chk_busy_on_write: assert property (i_wr_strobe && i_reg_addr == 8'h10 |=> o_busy)
    else $error("busy missing after command write");
  chk_addr_decode: assert property (!o_busy && i_wr_strobe && i_reg_addr != 8'h10 |=> !o_busy)
    else $error("write to another address started a command");
  chk_rd_freeze: assert property (i_rd_strobe && $past(i_rd_strobe)
    |-> $stable(o_sector_number) && $stable(o_sector_count))
    else $error("sector counters moved under read strobe");
  chk_complete_pulse: assert property (o_op_complete |=> !o_op_complete)
    else $error("complete longer than one cycle");
  chk_idle_gates: assert property (!o_busy |-> !o_read_gate && !o_write_gate)
    else $error("gate active while idle");
  chk_gate_splice: assert property (o_write_gate |-> !o_read_gate)
    else $error("read gate and write gate overlap");
  chk_error_hold: assert property (o_op_complete ##1 !o_busy |-> $stable(o_op_error))
    else $error("error flag changed before next load");
  chk_fifo_hold: assert property (o_buf_wr_valid && !i_buf_wr_ready
    |=> o_buf_wr_valid && $stable(o_buf_wr_data))
    else $error("buffer byte dropped while stalled");
  cover property (o_op_complete && o_op_error);
  cover property (o_write_gate);
  cover property (o_buf_wr_valid && i_buf_wr_ready);
endmodule
bind disk_command_issue disk_command_monitor i_disk_command_monitor (.*);

/* read_channel_model.sv */
// read channel model: free running byte clock, disk bytes and sync marks
`timescale 1ns/10ps
module read_channel_model (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_read_gate,
  output reg        o_byte_tick,
  output reg  [7:0] o_rd_byte,
  output reg        o_header_sync_found,
  output reg        o_data_sync_found
);
  reg [1:0] div_q;
  // sync marks only show while reading; bytes flip when the gate is off so stale data never looks valid
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 2'h0;
      o_byte_tick <= 1'b0;
      o_rd_byte <= 8'h00;
      o_header_sync_found <= 1'b0;
      o_data_sync_found <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      o_byte_tick <= (div_q == 2'h3);
      o_header_sync_found <= (div_q == 2'h3) && i_read_gate;
      o_data_sync_found <= (div_q == 2'h3) && i_read_gate;
      if (div_q == 2'h3)
        o_rd_byte <= i_read_gate ? o_rd_byte + 8'h01 : ~o_rd_byte;
    end
  end
endmodule

/* tb.sv */
// testbench for the disk command issue block
`timescale 1ns/10ps
module tb;
  reg         i_ref_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg  [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  reg         i_wr_strobe = 1'b0, i_rd_strobe = 1'b0, i_start_on_timer_zero = 1'b0, i_timer_zero = 1'b0;
  reg  [1:0]  i_drive_type = 2'h0, i_check_type = 2'h0;
  reg         i_index = 1'b0, i_header_match = 1'b0, i_header_check_en = 1'b0, i_data_check_en = 1'b0;
  reg         i_check_error = 1'b0, i_buf_rd_valid = 1'b1, i_buf_wr_ready = 1'b1;
  reg         i_sector_pulse = 1'b0, i_address_mark_found = 1'b0;
  reg  [3:0]  i_header_bytes = 4'h2;
  reg  [7:0]  i_sector_number_init = 8'h05, i_sector_count_init = 8'h03, i_gap_bytes = 8'h02;
  reg  [7:0]  i_post_index_gap_bytes = 8'h03, i_postamble_bytes = 8'h02, last_push = 8'hff;
  reg  [15:0] i_data_words = 16'h0008;
  wire        i_byte_tick, i_header_sync_found, i_data_sync_found, o_read_gate, o_write_gate;
  wire        o_busy, o_op_complete, o_op_error, o_buf_rd_ready, o_buf_wr_valid, o_buf_parity_check_en;
  wire [7:0]  i_rd_byte, i_buf_rd_data, o_buf_wr_data, o_wr_byte, o_sector_number, o_sector_count;
  integer     n_fail = 0, samples_checked = 0, pushes = 0, pulls = 0, gs = 0, wg = 0, i, k;
  assign i_buf_rd_data = pulls[7:0];
  always #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (o_buf_wr_valid && i_buf_wr_ready) begin
      pushes = pushes + 1;
      last_push = o_buf_wr_data;
    end
    // buffer byte steps after the edge that consumed it, never in the design's sampling step
    if (o_buf_rd_ready) pulls <= pulls + 1;
    if (o_read_gate || o_write_gate) gs = 1;
    if (o_write_gate) wg = 1;
  end
  disk_command_issue i_disk_command_issue (.*);
  read_channel_model i_read_channel_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_read_gate(o_read_gate),
    .o_byte_tick(i_byte_tick), .o_rd_byte(i_rd_byte), .o_header_sync_found(i_header_sync_found),
    .o_data_sync_found(i_data_sync_found));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d fails=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task nap(input integer n);
    begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      i_reg_addr = a;
      i_reg_wdata = d;
      i_wr_strobe = 1'b1;
      nap(1);
      i_wr_strobe = 1'b0;
      nap(1);
    end
  endtask
  // bounded wait for the one-cycle complete pulse, then the error level it qualifies
  task done(input e);
    begin
      k = 0;
      while (o_op_complete !== 1'b1 && k < 3000) begin
        nap(1);
        k = k + 1;
      end
      if (o_op_complete !== 1'b1) begin
        n_fail = n_fail + 1;
        end_of_test;
      end
      chk(o_op_error, e);
      nap(1);
    end
  endtask
  initial begin
    nap(16);
    i_rst = 1'b0;
    wr(8'h11, 8'h00);
    chk(o_busy, 1'b0);
    wr(8'h10, 8'h60);
    done(1'b0);
    chk(gs, 0);
    wr(8'h10, 8'hc0);
    nap(30);
    wr(8'h10, 8'h50);
    i_rd_strobe = 1'b1;
    nap(20);
    i_rd_strobe = 1'b0;
    done(1'b0);
    chk(o_sector_number, 8'h08);
    chk(o_sector_count, 8'h00);
    done(1'b1);
    for (i = 12; i <= 28; i = i + 4) begin
      wr(8'h10, 8'h40 | i[7:0]);
      done(1'b1);
    end
    i_drive_type = 2'h2;
    wr(8'h10, 8'h00);
    nap(40);
    chk(o_busy, 1'b1);
    i_index = 1'b1;
    nap(1);
    i_index = 1'b0;
    done(1'b0);
    i_drive_type = 2'h1;
    wr(8'h10, 8'h00);
    i_address_mark_found = 1'b1;
    nap(1);
    i_address_mark_found = 1'b0;
    nap(40);
    chk(o_busy, 1'b1);
    i_index = 1'b1;
    nap(1);
    i_index = 1'b0;
    i_address_mark_found = 1'b1;
    nap(1);
    i_address_mark_found = 1'b0;
    done(1'b0);
    i_drive_type = 2'h2;
    wr(8'h10, 8'h40);
    nap(40);
    chk(o_busy, 1'b1);
    i_sector_pulse = 1'b1;
    nap(1);
    i_sector_pulse = 1'b0;
    done(1'b0);
    i_drive_type = 2'h0;
    i_start_on_timer_zero = 1'b1;
    wr(8'h10, 8'h40);
    nap(40);
    chk(o_busy, 1'b1);
    i_timer_zero = 1'b1;
    nap(1);
    i_timer_zero = 1'b0;
    done(1'b0);
    i_start_on_timer_zero = 1'b0;
    i_header_bytes = 4'h3;
    i_header_match = 1'b1;
    pushes = 0;
    wr(8'h10, 8'h48);
    done(1'b0);
    nap(20);
    chk(pushes, 4);
    chk(last_push, 8'h00);
    i_header_match = 1'b0;
    wr(8'h10, 8'h48);
    nap(30);
    i_index = 1'b1;
    nap(1);
    i_index = 1'b0;
    nap(30);
    chk(o_busy, 1'b1);
    i_index = 1'b1;
    nap(1);
    i_index = 1'b0;
    done(1'b1);
    nap(20);
    i_header_match = 1'b1;
    i_header_bytes = 4'h2;
    for (i = 0; i < 4; i = i + 1) begin
      i_check_type = i[1:0];
      pushes = 0;
      wr(8'h10, 8'h47);
      done(1'b0);
      nap(20);
      chk(pushes, 16);
    end
    i_buf_wr_ready = 1'b0;
    wr(8'h10, 8'h4b);
    done(1'b1);
    i_buf_wr_ready = 1'b1;
    nap(20);
    wg = 0;
    pulls = 0;
    wr(8'h10, 8'h46);
    done(1'b0);
    chk(wg, 1);
    chk(pulls, 16);
    chk(o_wr_byte, 8'h0f);
    i_buf_rd_valid = 1'b0;
    wr(8'h10, 8'h45);
    nap(10);
    chk(o_buf_parity_check_en, 1'b1);
    done(1'b1);
    wr(8'h10, 8'h49);
    nap(10);
    chk(o_buf_parity_check_en, 1'b0);
    done(1'b1);
    i_buf_rd_valid = 1'b1;
    i_check_error = 1'b1;
    i_data_check_en = 1'b1;
    wr(8'h10, 8'h44);
    done(1'b1);
    i_data_check_en = 1'b0;
    wr(8'h10, 8'h44);
    done(1'b0);
    i_header_check_en = 1'b1;
    wr(8'h10, 8'h44);
    done(1'b1);
    i_header_check_en = 1'b0;
    i_check_error = 1'b0;
    wr(8'h10, 8'h47);
    nap(30);
    chk(o_read_gate, 1'b1);
    i_rst = 1'b1;
    nap(2);
    chk(o_busy, 1'b0);
    chk(o_read_gate, 1'b0);
    i_rst = 1'b0;
    wr(8'h10, 8'h40);
    done(1'b0);
    end_of_test;
  end
endmodule
